/* hdl/pcp_params.svh */
// Purpose: constants of the pixel correction pipeline
// Assumes: included by bare name
// Notes: definitions only
`ifndef PCP_PARAMS_SVH
`define PCP_PARAMS_SVH

`define PCP_REG_CTRL 8'h00
`define PCP_REG_TARGET 8'h04
`define PCP_REG_CMD 8'h08
`define PCP_REG_STATUS 8'h0c
`define PCP_REG_UDEF0 8'h10
`define PCP_REG_UDEF3 8'h1c

`define PCP_CTRL_HOT 0
`define PCP_CTRL_FIX 1
`define PCP_CTRL_MODE 2
`define PCP_CTRL_SLOT 4
`define PCP_CMD_BUILD 0
`define PCP_CMD_STORE 1
`define PCP_CMD_RESTORE 2
`define PCP_UDEF_X 0
`define PCP_UDEF_Y 8
`define PCP_UDEF_EN 31

`define PCP_TARGET_RST 12'h800
`define PCP_PIX_MAX 12'hfff
`define PCP_LAST_COORD 6'h3f
`define PCP_DARK_OFS 12'h004
`define PCP_HOT_THRESH 13'h0200
`define PCP_RESP_TRIM 64'h0123_3210_1232_2101
`define PCP_FACTORY_DEFECTS 48'h868_294_086_085
`define PCP_SLOT_LAST 4'hb
`define PCP_ACTIVE_REGION 4'hc
`define PCP_GRID_PTS 9'd25
`define PCP_GRID_LAST_PT 3'd4
`define PCP_FLUSH_LEN 2'd3
`define PCP_PREP_LEN 4'd10
`define PCP_COPY_LEN 5'd25
`define PCP_AXI_OKAY 2'b00
`define PCP_AXI_SLVERR 2'b10

`endif

/* hdl/pcp_pkg.sv */
// Purpose: shared types of the pixel correction pipeline
// Assumes: nothing
// Notes: constants live in pcp_params.svh
package pcp_pkg;
  typedef enum logic [1:0] {ST_PREP, ST_RUN, ST_FLUSH, ST_COPY} pcp_state_e;
  typedef logic [11:0] pcp_pix_t;
endpackage

/* hdl/pcp_flat_mem.sv */
// Purpose: flat data store, twelve user slots plus the active set
// Assumes: one write and one read port on mclk
// Notes: array has no reset so slot contents survive a reset
`timescale 1ns/1ps
module pcp_flat_mem (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic we,
  input wire logic [8:0] wrAddr,
  input wire pcp_pkg::pcp_pix_t wrData,
  input wire logic [8:0] rdAddr,
  output pcp_pkg::pcp_pix_t rdData
);
  pcp_pkg::pcp_pix_t mem [0:511];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= 12'h000;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

/* hdl/pcp_pixel_correction.sv */
// Purpose: defect, hot spot, non-uniformity and shading correction of a 64x64 12-bit stream
// Assumes: pixels raster order, registers over AXI4-Lite
// Notes: stream stalls for row preparation and slot copies
// Overview of operation
// [R1] defect gets mean of nearest valid line neighbours
// [R2] one nearest neighbour bad: copy the other
// [R3] both bad: second pair, then third pair
// [R4] factory list plus user coordinates mark defects
// [R5] hot spot removal only while enabled
// [R6] fixed dark offset and response gains applied
// [R7] corrected level is original over flat level
// [R8] shading fix only while enabled, else pass
// [R9] build command samples next frame into active
// [R10] flat grid expanded by bilinear interpolation
// [R11] slot select picks store target, restore source
// [R12] store copies active set into chosen slot
// [R13] restore overwrites active set, drops built data
// [R14] target is automatic or user programmed
// [R15] user target 1 to 4095, 12-bit scale
// [R16] host zeroes offsets, maximal size before build
// [R17] host supplies one frame after build
// [R18] host should enable defect fix before build
// [R19] quotient scaled by target, saturated, zero flat full
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "pcp_params.svh"
`timescale 1ns/1ps
module pcp_pixel_correction (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire pcp_pkg::pcp_pix_t pixData,
  input wire logic pixValid,
  output logic pixReady,
  output pcp_pkg::pcp_pix_t outData,
  output logic outValid
);
  function automatic logic [11:0] avg2(input logic [11:0] a, input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    avg2 = s[12:1];
  endfunction

  // result lies between a and b, so modulo-4096 addition is exact
  function automatic logic [11:0] lerp(input logic [11:0] a, input logic [11:0] b, input logic [3:0] f);
    logic signed [18:0] d;
    d = ($signed({7'h00, b}) - $signed({7'h00, a})) * $signed({15'h0000, f});
    lerp = a + d[15:4];
  endfunction

  function automatic logic [31:0] wMerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      wMerge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  pcp_pkg::pcp_state_e state_reg, stateNext;
  logic hotEn_reg, fixEn_reg, userMode_reg, activeValid_reg, buildArmed_reg, buildLive_reg;
  logic storePend_reg, restorePend_reg;
  logic [3:0] slot_reg;
  logic [11:0] target_reg, autoTarget_reg, tmpA_reg;
  logic [31:0] udef_reg [0:3];
  logic [11:0] rowVal_reg [0:4];
  logic [5:0] xIn_reg, yIn_reg, xNext, yNext;
  logic [3:0] prepCnt_reg;
  logic [1:0] flushCnt_reg;
  logic [4:0] cpyCnt_reg;
  logic awHeld_reg, wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  // register bus
  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire arTake = arvalid && arready;
  wire doWrite = awHeld_reg && wHeld_reg && !bvalid;
  wire [7:0] wAddr = {awAddr_reg[7:2], 2'b00};
  wire [7:0] rAddr = {araddr[7:2], 2'b00};
  wire [31:0] ctrlWord = {24'h000000, slot_reg, 1'b0, userMode_reg, fixEn_reg, hotEn_reg};
  wire [31:0] ctrlNew = wMerge(ctrlWord, wData_reg, wStrb_reg);
  wire [31:0] targetNew = wMerge({20'h00000, target_reg}, wData_reg, wStrb_reg);
  wire [31:0] statusWord = {4'h0, autoTarget_reg, 11'h000, restorePend_reg, storePend_reg,
                            buildLive_reg, buildArmed_reg, activeValid_reg};
  logic wrCtrl, wrTarget, wrCmd, wrUdef, wHit, rHit;
  logic [31:0] rdWord;

  always_comb begin
    wrCtrl = 1'b0;
    wrTarget = 1'b0;
    wrCmd = 1'b0;
    wrUdef = 1'b0;
    if (wAddr == `PCP_REG_CTRL) begin
      wrCtrl = doWrite;
    end else if (wAddr == `PCP_REG_TARGET) begin
      wrTarget = doWrite;
    end else if (wAddr == `PCP_REG_CMD) begin
      wrCmd = doWrite;
    end else if (wAddr >= `PCP_REG_UDEF0 && wAddr <= `PCP_REG_UDEF3) begin
      wrUdef = doWrite;
    end
    wHit = wrCtrl || wrTarget || wrCmd || wrUdef;
  end

  always_comb begin
    rdWord = 32'h00000000;
    rHit = 1'b1;
    if (rAddr == `PCP_REG_CTRL) begin
      rdWord = ctrlWord;
    end else if (rAddr == `PCP_REG_TARGET) begin
      rdWord = {20'h00000, target_reg};
    end else if (rAddr == `PCP_REG_CMD) begin
      rdWord = 32'h00000000;
    end else if (rAddr == `PCP_REG_STATUS) begin
      rdWord = statusWord;
    end else if (rAddr >= `PCP_REG_UDEF0 && rAddr <= `PCP_REG_UDEF3) begin
      rdWord = udef_reg[rAddr[3:2]];
    end else begin
      rHit = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `PCP_AXI_OKAY;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `PCP_AXI_OKAY;
    end else begin
      awHeld_reg <= (awHeld_reg && !doWrite) || awTake;
      wHeld_reg <= (wHeld_reg && !doWrite) || wTake;
      awready <= !((awHeld_reg && !doWrite) || awTake);
      wready <= !((wHeld_reg && !doWrite) || wTake);
      if (awTake) awAddr_reg <= awaddr;
      if (wTake) begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      bvalid <= doWrite || (bvalid && !bready);
      if (doWrite) bresp <= wHit ? `PCP_AXI_OKAY : `PCP_AXI_SLVERR;
      rvalid <= arTake || (rvalid && !rready);
      arready <= !(arTake || (rvalid && !rready));
      if (arTake) begin
        rdata <= rdWord;
        rresp <= rHit ? `PCP_AXI_OKAY : `PCP_AXI_SLVERR;
      end
    end
  end

  // stage A: dark offset and block response gain
  wire accept = pixValid && pixReady && state_reg == pcp_pkg::ST_RUN;
  wire [11:0] darkSub = (pixData > `PCP_DARK_OFS) ? pixData - `PCP_DARK_OFS : 12'h000;
  wire [63:0] respTrim = `PCP_RESP_TRIM;
  wire [3:0] blk = {yIn_reg[5:4], xIn_reg[5:4]};
  wire [8:0] gain = 9'h100 + {5'h00, respTrim[{blk, 2'b00} +: 4]};
  wire [20:0] respProd = darkSub * gain;
  wire [47:0] factoryList = `PCP_FACTORY_DEFECTS;
  logic [7:0] defHit;
  logic [11:0] aPix;
  logic [11:0] aXY;
  logic aVal, aDef;

  for (genvar i = 0; i < 8; i++) begin : g_defect
    if (i < 4) begin : g_factory
      assign defHit[i] = factoryList[12*i +: 12] == {yIn_reg, xIn_reg};
    end else begin : g_user
      assign defHit[i] = udef_reg[i-4][`PCP_UDEF_EN] && udef_reg[i-4][`PCP_UDEF_Y +: 6] == yIn_reg &&
                         udef_reg[i-4][`PCP_UDEF_X +: 6] == xIn_reg; // see [R4]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aVal <= 1'b0;
      aDef <= 1'b0;
      aPix <= 12'h000;
      aXY <= 12'h000;
    end else begin
      aVal <= accept;
      aDef <= |defHit; // see [R4]
      aPix <= respProd[20] ? `PCP_PIX_MAX : respProd[19:8]; // see [R6]
      aXY <= {yIn_reg, xIn_reg};
    end
  end

  // seven-tap line window, slot 3 is the pixel under repair, lower index lies to the right
  wire flushSlot = state_reg == pcp_pkg::ST_FLUSH && !aVal;
  wire winShift = aVal || flushSlot;
  logic [11:0] winPix [0:6];
  logic [11:0] winXY [0:6];
  logic winLive [0:6];
  logic winDef [0:6];
  logic ok [0:6];
  logic ctrStrobe;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      winPix[0] <= 12'h000;
      winXY[0] <= 12'h000;
      winLive[0] <= 1'b0;
      winDef[0] <= 1'b0;
      ctrStrobe <= 1'b0;
    end else begin
      ctrStrobe <= winShift;
      if (winShift) begin
        winPix[0] <= aPix;
        winXY[0] <= aXY;
        winLive[0] <= aVal;
        winDef[0] <= aDef;
      end
    end
  end

  for (genvar i = 0; i < 7; i++) begin : g_win
    assign ok[i] = winLive[i] && !winDef[i];
    if (i > 0) begin : g_tap
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          winPix[i] <= 12'h000;
          winXY[i] <= 12'h000;
          winLive[i] <= 1'b0;
          winDef[i] <= 1'b0;
        end else if (winShift) begin
          winPix[i] <= winPix[i-1];
          winXY[i] <= winXY[i-1];
          winLive[i] <= winLive[i-1];
          winDef[i] <= winDef[i-1];
        end
      end
    end
  end

  wire isHot = ok[4] && ok[2] && ({1'b0, winPix[3]} > {1'b0, winPix[4]} + `PCP_HOT_THRESH) &&
               ({1'b0, winPix[3]} > {1'b0, winPix[2]} + `PCP_HOT_THRESH);
  logic [11:0] fixedPix;

  // dead slots (line edges, flush) count as invalid neighbours; all six bad keeps the raw value
  always_comb begin
    logic found;
    found = 1'b0;
    fixedPix = winPix[3];
    if (winDef[3]) begin
      for (int k = 1; k <= 3; k++) begin
        if (!found && ok[3+k] && ok[3-k]) begin
          fixedPix = avg2(winPix[3+k], winPix[3-k]); // see [R1] see [R3]
          found = 1'b1;
        end else if (!found && ok[3+k]) begin
          fixedPix = winPix[3+k]; // see [R2] see [R3]
          found = 1'b1;
        end else if (!found && ok[3-k]) begin
          fixedPix = winPix[3-k]; // see [R2] see [R3]
          found = 1'b1;
        end
      end
    end else if (hotEn_reg && isHot) begin
      fixedPix = avg2(winPix[4], winPix[2]); // see [R5]
    end
  end

  // stage C and shading stage
  logic cVal;
  logic [11:0] cPix;
  logic [5:0] cX, cY;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cVal <= 1'b0;
      cPix <= 12'h000;
      cX <= 6'h00;
      cY <= 6'h00;
    end else begin
      cVal <= ctrStrobe && winLive[3];
      cPix <= fixedPix;
      {cY, cX} <= winXY[3];
    end
  end

  wire [2:0] seg = {1'b0, cX[5:4]};
  wire [2:0] segNext = seg + 3'd1;
  wire [11:0] flatH = lerp(rowVal_reg[seg], rowVal_reg[segNext], cX[3:0]); // see [R10]
  wire fixActive = fixEn_reg && activeValid_reg;
  wire [11:0] userTarget = (target_reg == 12'h000) ? 12'h001 : target_reg; // see [R15]
  wire [11:0] autoUse = (autoTarget_reg == 12'h000) ? `PCP_PIX_MAX : autoTarget_reg;
  wire [11:0] targetUse = userMode_reg ? userTarget : autoUse; // see [R14]
  wire [23:0] numer = cPix * targetUse;
  // single-cycle divider: the long pole for timing at 200 MHz
  wire [23:0] quot = numer / {12'h000, flatH}; // see [R7]
  wire [11:0] flatOut = (flatH == 12'h000 || quot > {12'h000, `PCP_PIX_MAX}) ? `PCP_PIX_MAX : quot[11:0];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      outValid <= 1'b0;
      outData <= 12'h000;
    end else begin
      outValid <= cVal;
      if (cVal) outData <= fixActive ? flatOut : cPix; // see [R8] see [R19]
    end
  end

  // flat data store, build, copy and row preparation
  wire slotOk = slot_reg <= `PCP_SLOT_LAST;
  wire anyPend = storePend_reg || restorePend_reg;
  wire [3:0] srcRegion = storePend_reg ? `PCP_ACTIVE_REGION : slot_reg; // see [R11]
  wire [3:0] dstRegion = storePend_reg ? slot_reg : `PCP_ACTIVE_REGION; // see [R12]
  wire [8:0] activeBase = 9'(`PCP_ACTIVE_REGION) * `PCP_GRID_PTS;
  wire [8:0] cpyRd = 9'(srcRegion) * `PCP_GRID_PTS + 9'(cpyCnt_reg);
  wire [8:0] cpyWr = 9'(dstRegion) * `PCP_GRID_PTS + 9'(cpyCnt_reg) - 9'd1;
  wire [2:0] prepRow = {1'b0, yIn_reg[5:4]} + {2'b00, prepCnt_reg[0]};
  wire [8:0] prepRd = activeBase + 9'(prepRow) * 9'd5 + 9'(prepCnt_reg[3:1]);
  wire inCopy = state_reg == pcp_pkg::ST_COPY && slotOk;
  wire cpyWe = inCopy && cpyCnt_reg != 5'd0;
  wire restoreStart = inCopy && cpyCnt_reg == 5'd0 && !storePend_reg;
  wire cpyDone = inCopy && cpyCnt_reg == `PCP_COPY_LEN;
  wire buildStart = cVal && buildArmed_reg && !buildLive_reg && cX == 6'h00 && cY == 6'h00;
  wire buildNow = cVal && (buildLive_reg || buildStart);
  wire buildEnd = buildNow && cX == `PCP_LAST_COORD && cY == `PCP_LAST_COORD;
  wire onGrid = (cX[3:0] == 4'h0 || cX == `PCP_LAST_COORD) && (cY[3:0] == 4'h0 || cY == `PCP_LAST_COORD);
  wire [2:0] gx = (cX == `PCP_LAST_COORD) ? `PCP_GRID_LAST_PT : {1'b0, cX[5:4]};
  wire [2:0] gy = (cY == `PCP_LAST_COORD) ? `PCP_GRID_LAST_PT : {1'b0, cY[5:4]};
  wire buildWe = buildNow && onGrid; // see [R9]
  wire [8:0] buildWr = activeBase + 9'(gy) * 9'd5 + 9'(gx);
  wire memWe = cpyWe || buildWe;
  wire [8:0] memWrAddr = cpyWe ? cpyWr : buildWr;
  wire [8:0] memRdAddr = (state_reg == pcp_pkg::ST_COPY) ? cpyRd : prepRd;
  pcp_pkg::pcp_pix_t memRd;
  wire [11:0] memWrData = cpyWe ? memRd : cPix;
  wire [2:0] cmdBits = (wrCmd && wStrb_reg[0]) ? wData_reg[2:0] : 3'b000;

  pcp_flat_mem pcp_flat_mem_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .we(memWe),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddr(memRdAddr),
    .rdData(memRd)
  );

  always_comb begin
    stateNext = state_reg;
    case (state_reg)
      pcp_pkg::ST_PREP: if (prepCnt_reg == `PCP_PREP_LEN) stateNext = pcp_pkg::ST_RUN;
      pcp_pkg::ST_RUN: begin
        if (accept && xIn_reg == `PCP_LAST_COORD) stateNext = pcp_pkg::ST_FLUSH;
        else if (!accept && xIn_reg == 6'h00 && anyPend) stateNext = pcp_pkg::ST_COPY;
      end
      pcp_pkg::ST_FLUSH: if (flushSlot && flushCnt_reg == `PCP_FLUSH_LEN - 2'd1) stateNext = pcp_pkg::ST_PREP;
      default: if (!slotOk || cpyDone) stateNext = pcp_pkg::ST_PREP;
    endcase
  end

  assign xNext = accept ? xIn_reg + 6'h01 : xIn_reg;
  assign yNext = (accept && xIn_reg == `PCP_LAST_COORD) ? yIn_reg + 6'h01 : yIn_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= pcp_pkg::ST_PREP;
      pixReady <= 1'b0;
      xIn_reg <= 6'h00;
      yIn_reg <= 6'h00;
      prepCnt_reg <= 4'h0;
      flushCnt_reg <= 2'b00;
      cpyCnt_reg <= 5'h00;
      tmpA_reg <= 12'h000;
      for (int g = 0; g < 5; g++) rowVal_reg[g] <= 12'h000;
    end else begin
      state_reg <= stateNext;
      pixReady <= stateNext == pcp_pkg::ST_RUN && !(xNext == 6'h00 && anyPend);
      xIn_reg <= xNext;
      yIn_reg <= yNext;
      prepCnt_reg <= (state_reg == pcp_pkg::ST_PREP) ? prepCnt_reg + 4'h1 : 4'h0;
      flushCnt_reg <= (state_reg == pcp_pkg::ST_FLUSH) ? flushCnt_reg + 2'(flushSlot) : 2'b00;
      cpyCnt_reg <= inCopy ? cpyCnt_reg + 5'h01 : 5'h00;
      if (state_reg == pcp_pkg::ST_PREP && prepCnt_reg != 4'h0) begin
        if (prepCnt_reg[0]) tmpA_reg <= memRd;
        else rowVal_reg[prepCnt_reg[3:1] - 3'd1] <= lerp(tmpA_reg, memRd, yIn_reg[3:0]); // see [R10]
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hotEn_reg <= 1'b0;
      fixEn_reg <= 1'b0;
      userMode_reg <= 1'b0;
      slot_reg <= 4'h0;
      target_reg <= `PCP_TARGET_RST;
      activeValid_reg <= 1'b0;
      buildArmed_reg <= 1'b0;
      buildLive_reg <= 1'b0;
      storePend_reg <= 1'b0;
      restorePend_reg <= 1'b0;
      autoTarget_reg <= 12'h000;
      for (int u = 0; u < 4; u++) udef_reg[u] <= 32'h00000000;
    end else begin
      if (wrUdef) udef_reg[wAddr[3:2]] <= wMerge(udef_reg[wAddr[3:2]], wData_reg, wStrb_reg); // see [R4]
      if (wrCtrl) begin
        hotEn_reg <= ctrlNew[`PCP_CTRL_HOT]; // see [R5]
        fixEn_reg <= ctrlNew[`PCP_CTRL_FIX]; // see [R8]
        userMode_reg <= ctrlNew[`PCP_CTRL_MODE]; // see [R14]
        slot_reg <= ctrlNew[`PCP_CTRL_SLOT +: 4]; // see [R11]
      end
      if (wrTarget) target_reg <= targetNew[11:0]; // see [R15]
      // a command written in the cycle its flag clears is kept
      buildArmed_reg <= (buildArmed_reg && !buildStart && !restoreStart) || cmdBits[`PCP_CMD_BUILD];
      storePend_reg <= (storePend_reg && !(inCopy ? cpyDone : state_reg == pcp_pkg::ST_COPY)) ||
                       cmdBits[`PCP_CMD_STORE]; // see [R12]
      restorePend_reg <= (restorePend_reg && !((inCopy && cpyDone && !storePend_reg) ||
                         (state_reg == pcp_pkg::ST_COPY && !slotOk))) || cmdBits[`PCP_CMD_RESTORE];
      if (buildStart) buildLive_reg <= 1'b1;
      else if (buildEnd || restoreStart) buildLive_reg <= 1'b0; // see [R13]
      if (buildEnd || (cpyDone && !storePend_reg)) activeValid_reg <= 1'b1; // see [R9] see [R13]
      if (buildStart || restoreStart) autoTarget_reg <= 12'h000;
      else if (memWe && memWrAddr >= activeBase && memWrData > autoTarget_reg) autoTarget_reg <= memWrData;
    end
  end

  property p_nearAvg;
    @(posedge mclk) disable iff (!reset_n)
    (ctrStrobe && winLive[3] && winDef[3] && ok[4] && ok[2]) |=> (cVal && cPix == avg2($past(winPix[4]), $past(winPix[2])));
  endproperty
  a_nearAvg: assert property (p_nearAvg) else $error("nearest pair mean wrong"); // see [R1]
  property p_oneSide;
    @(posedge mclk) disable iff (!reset_n)
    (ctrStrobe && winLive[3] && winDef[3] && !ok[4] && ok[2]) |=> cPix == $past(winPix[2]);
  endproperty
  a_oneSide: assert property (p_oneSide) else $error("single neighbour copy wrong"); // see [R2]
  property p_secondPair;
    @(posedge mclk) disable iff (!reset_n)
    (ctrStrobe && winLive[3] && winDef[3] && !ok[4] && !ok[2] && ok[5] && ok[1])
      |=> cPix == avg2($past(winPix[5]), $past(winPix[1]));
  endproperty
  a_secondPair: assert property (p_secondPair) else $error("second pair mean wrong"); // see [R3]
  property p_userDefect;
    @(posedge mclk) disable iff (!reset_n)
    (accept && udef_reg[0][`PCP_UDEF_EN] && udef_reg[0][13:8] == yIn_reg && udef_reg[0][5:0] == xIn_reg)
      |=> (aVal && aDef);
  endproperty
  a_userDefect: assert property (p_userDefect) else $error("user defect not flagged"); // see [R4]
  property p_hotOff;
    @(posedge mclk) disable iff (!reset_n)
    (ctrStrobe && winLive[3] && !winDef[3] && !hotEn_reg) |=> cPix == $past(winPix[3]);
  endproperty
  a_hotOff: assert property (p_hotOff) else $error("pixel changed with hot removal off"); // see [R5]
  property p_darkFloor;
    @(posedge mclk) disable iff (!reset_n)
    (accept && pixData <= `PCP_DARK_OFS) |=> (aVal && aPix == 12'h000);
  endproperty
  a_darkFloor: assert property (p_darkFloor) else $error("dark offset not removed"); // see [R6]
  property p_quotient;
    @(posedge mclk) disable iff (!reset_n)
    // checked as a division identity so a wrong divider cannot agree with itself
    (cVal && fixActive && flatH != 12'h000 && numer < {flatH, 12'h000})
      |=> (24'(outData) * 24'($past(flatH)) <= $past(numer)) &&
          ($past(numer) < (24'(outData) + 24'd1) * 24'($past(flatH)));
  endproperty
  a_quotient: assert property (p_quotient) else $error("shading quotient wrong"); // see [R7]
  property p_bypass;
    @(posedge mclk) disable iff (!reset_n)
    (cVal && !fixActive) |=> (outValid && outData == $past(cPix));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered pixel"); // see [R8]
  property p_zeroFlat;
    @(posedge mclk) disable iff (!reset_n)
    (cVal && fixActive && flatH == 12'h000) |=> outData == `PCP_PIX_MAX;
  endproperty
  a_zeroFlat: assert property (p_zeroFlat) else $error("zero flat not full scale"); // see [R19]
endmodule

/* sim/pcp_sensor_model.sv */
// Purpose: sensor readout stand-in, endless raster with a ramp, a hot spike and a dark column
// Assumes: run held high once streaming starts
// Notes: data inverts while idle so nothing stale looks valid; columns 0, 48 and 63 stay at the plain level
`timescale 1ns/1ps
module pcp_sensor_model #(
  parameter logic [11:0] LEVEL = 12'h400
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic pixReady,
  output pcp_pkg::pcp_pix_t pixData,
  output logic pixValid
);
  logic [5:0] col;
  // the next column is presented only once the current pixel is taken
  wire [5:0] colNext = (pixValid && pixReady) ? col + 6'h01 : col;
  wire [11:0] ramp = (colNext < 6'h10) ? {4'h0, colNext, 2'b00} : 12'h000;
  wire [11:0] shade = (colNext == 6'h24) ? LEVEL + 12'h300 : LEVEL + ramp;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pixValid <= 1'b0;
      pixData <= ~LEVEL;
      col <= 6'h00;
    end else begin
      pixValid <= run;
      col <= colNext;
      // column 32 is near black so its flat sample comes out zero
      pixData <= run ? ((colNext == 6'h20) ? 12'h002 : shade) : ~pixData;
    end
  end
endmodule

/* sim/tb_pixel_correction_pipeline.sv */
// Purpose: register and stream checks of the correction pipeline
// Assumes: constant input level, outputs taken in raster order
// Notes: flat grid columns other than the dark column 32 keep the plain level, so shaded grid pixels there land on the target
`include "pcp_params.svh"
`timescale 1ns/1ps
module tb_pixel_correction_pipeline;
  logic mclk = 0, reset_n = 0, run = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rd;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, pixValid, pixReady, outValid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata;
  pcp_pkg::pcp_pix_t pixData, outData, p0;
  pcp_pkg::pcp_pix_t img [4096];
  int k = 0, cyc = 0, n_mismatch = 0, n_compared = 0;
  initial forever #2.5 mclk = ~mclk;
  pcp_pixel_correction pcp_pixel_correction_inst (.mclk(mclk), .reset_n(reset_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pixData(pixData), .pixValid(pixValid),
    .pixReady(pixReady), .outData(outData), .outValid(outValid));
  pcp_sensor_model pcp_sensor_model_inst (.mclk(mclk), .reset_n(reset_n), .run(run), .pixReady(pixReady),
    .pixData(pixData), .pixValid(pixValid));
  always @(posedge mclk) begin
    cyc++;
    if (outValid === 1'b1) begin
      img[k % 4096] <= outData;
      k <= k + 1;
    end
    if (cyc == 70000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    // either channel may be taken first, so each drops on its own
    forever begin
      @(posedge mclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    forever begin
      @(posedge mclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 0;
  endtask
  task automatic waitk(input int n);
    while (k < n) @(posedge mclk);
    $display("test done at %0d pixels", n);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1;
    rdr(`PCP_REG_CTRL); chk(rd, 0); chk(rs, `PCP_AXI_OKAY);
    rdr(`PCP_REG_TARGET); chk(rd, `PCP_TARGET_RST);
    rdr(`PCP_REG_STATUS); chk(rd, 0);
    rdr(8'h20); chk(rd, 0); chk(rs, `PCP_AXI_SLVERR);
    wr(8'h20, 1); chk(bresp, `PCP_AXI_SLVERR);
    wr(`PCP_REG_UDEF0, 32'h8000_030a);
    wr(`PCP_REG_TARGET, 32'h100);
    rdr(`PCP_REG_TARGET); chk(rd, 32'h100);
    rdr(`PCP_REG_CMD); chk(rd, 0);
    wr(`PCP_REG_CTRL, 32'h4);
    run <= 1;
    waitk(4096);
    p0 = img[0];
    // (5,2) and (6,2) are adjacent factory defects, (10,3) is the user entry
    chk(img[133], img[132]);
    chk(img[134], img[135]);
    chk(img[202], (32'(img[201]) + 32'(img[203])) >> 1);
    chk(img[32], 0);
    wr(`PCP_REG_CMD, 1);
    waitk(3 * 4096 + 64);
    rdr(`PCP_REG_STATUS); chk(rd[0], 1);
    wr(`PCP_REG_CTRL, 32'h6);
    waitk(5 * 4096 + 64);
    // (0,0) sees its own flat sample and (63,63) a blend of equal samples, so the target comes out
    chk(img[0], 12'h100);
    chk(img[4095], 12'h100);
    chk(img[32], `PCP_PIX_MAX);
    wr(`PCP_REG_CTRL, 32'h36);
    wr(`PCP_REG_CMD, 2);
    wr(`PCP_REG_CMD, 4);
    waitk(6 * 4096 + 64);
    rdr(`PCP_REG_STATUS); chk(rd[4:0], 5'h01);
    chk(img[0], 12'h100);
    wr(`PCP_REG_CTRL, 32'h32);
    waitk(7 * 4096 + 64);
    rdr(`PCP_REG_STATUS); chk(img[0], rd[27:16]);
    wr(`PCP_REG_CTRL, 32'h4);
    waitk(8 * 4096 + 64);
    chk(img[0], p0);
    chk(img[36] == img[35], 0);
    wr(`PCP_REG_CTRL, 32'h5);
    waitk(9 * 4096 + 64);
    chk(img[36], img[35]);
    conclude();
  end
endmodule
